// ===== include/tdr_pkg.sv
// Package with register map, field positions and encodings for the DES register block.
//------------------------------------------------------------------------------
// Summary of operation
// (RULE1) Mask register is read-only; bit 0 done, bits 1-4 buffer flags, bit 8 illegal.
// (RULE2) Block done flag sets when a block finishes; zero means output words invalid.
// (RULE3) Block done flag clears on start bit write and on soft reset bit write.
// (RULE4) Last-output mode off, manual or auto: reading an output word clears done flag.
// (RULE5) Last-output mode on, manual or auto: writing an input word clears done flag.
// (RULE6) In DMA start mode the done flag is set and cleared by the engine itself.
// (RULE7) Bit 1 shows receive counter reached zero since last receive count write.
// (RULE8) Bit 2 shows transmit counter reached zero since last transmit count write.
// (RULE9) Bit 3 reads one only while receive count and next receive count are zero.
// (RULE10) Bit 4 reads one only while transmit count and next count are zero.
// (RULE11) Illegal-access bit 8 sets on bad access, cleared only by soft reset.
// (RULE12) Access type at bits 13:12: 00 input,01 output,10 mode write,11 write-only read.
// (RULE13) Access type keeps only the latest code, reset only by soft reset.
// (RULE14) Three 64-bit keys, each two write-only words, first then last, never readable.
// (RULE15) Single DES uses only the first key; second key words are ignored.
// (RULE16) Third key words ignored in single DES and in two-key triple DES.
// (RULE17) Input block is two write-only words, word one first part, word two last.
// (RULE18) Output block is two read-only words, word one first part, word two last.
// (RULE19) Initialization vector is two write-only words, word one first, word two last.
// (RULE20) Software must not write the vector words in electronic code book mode.
// (RULE21) Enable register write ones set mask bits, disable register ones clear them.
// (RULE22) Key count select one picks two-key algorithm, zero picks three-key.
// (RULE23) Interrupt request high while any flag and its mask bit are both set.
// (RULE24) Reading a write-only register returns zero and records access type 11.
//------------------------------------------------------------------------------
package tdr_pkg;
  localparam logic [11:0] ADDR_CTRL  = 12'h000;
  localparam logic [11:0] ADDR_MODE  = 12'h004;
  localparam logic [11:0] ADDR_IEN   = 12'h010;
  localparam logic [11:0] ADDR_IDIS  = 12'h014;
  localparam logic [11:0] ADDR_IMASK = 12'h018;
  localparam logic [11:0] ADDR_ISTAT = 12'h01c;
  localparam logic [11:0] ADDR_KEY1  = 12'h020;
  localparam logic [11:0] ADDR_KEY2  = 12'h028;
  localparam logic [11:0] ADDR_KEY3  = 12'h030;
  localparam logic [11:0] ADDR_IDATA = 12'h040;
  localparam logic [11:0] ADDR_ODATA = 12'h050;
  localparam logic [11:0] ADDR_IV    = 12'h060;
  localparam logic [11:0] ADDR_RCNT  = 12'h104;
  localparam logic [11:0] ADDR_RNCNT = 12'h114;
  localparam logic [11:0] ADDR_TCNT  = 12'h10c;
  localparam logic [11:0] ADDR_TNCNT = 12'h11c;
  // Control bits.
  localparam int CTRL_START = 0;
  localparam int CTRL_SRST  = 8;
  // Mode register fields.
  localparam int MODE_CIPHER = 0;
  localparam int MODE_TRIPLE = 1;
  localparam int MODE_KEYSEL = 4;
  localparam int MODE_SM_LO  = 8;
  localparam int MODE_LOD    = 15;
  localparam logic [31:0] MODE_WMASK = 32'h0003_b313;
  localparam logic [1:0] SM_MANUAL = 2'h0;
  localparam logic [1:0] SM_AUTO   = 2'h1;
  localparam logic [1:0] SM_DMA    = 2'h2;
  // Status bit positions.
  localparam int ST_DONE = 0;
  localparam int ST_ERX  = 1;
  localparam int ST_ETX  = 2;
  localparam int ST_RXF  = 3;
  localparam int ST_TXE  = 4;
  localparam int ST_ILL  = 8;
  localparam int ST_TYP  = 12;
  localparam logic [31:0] IRQ_BITS = 32'h0000_011f;
  localparam logic [1:0] ILL_IN_DMA  = 2'h0;
  localparam logic [1:0] ILL_OUT_RD  = 2'h1;
  localparam logic [1:0] ILL_MODE_WR = 2'h2;
  localparam logic [1:0] ILL_WO_RD   = 2'h3;
  // Engine timing.
  localparam logic [5:0] ENGINE_CYCLES = 6'd48;
  typedef enum logic [2:0] {
    TDR_IDLE = 3'b001,
    TDR_BUSY = 3'b010,
    TDR_DONE = 3'b100
  } tdr_state_e;
endpackage : tdr_pkg

// ===== design/tdr_regs.sv
// DES register block: APB slave, status flags, key/data/vector storage and engine sequencer.
`timescale 1ns/100ps
module tdr_regs (
  input  wire logic        CLOCK,
  input  wire logic        SRST,
  input  wire logic        PSEL,
  input  wire logic        PENABLE,
  input  wire logic        PWRITE,
  input  wire logic [11:0] PADDR,
  input  wire logic [31:0] PWDATA,
  output logic      [31:0] PRDATA,
  output logic             PREADY,
  output logic             PSLVERR,
  input  wire logic        RX_DMA_ZERO,
  input  wire logic        TX_DMA_ZERO,
  input  wire logic [63:0] ENGINE_RESULT,
  output logic      [63:0] ENGINE_BLOCK,
  output logic      [63:0] ENGINE_KEY1,
  output logic      [63:0] ENGINE_KEY2,
  output logic      [63:0] ENGINE_KEY3,
  output logic      [63:0] ENGINE_IV,
  output logic             ENGINE_START,
  output logic             IRQ
);
  import tdr_pkg::*;

  //----------------------------------------------------------------------------
  // Bus decode
  //----------------------------------------------------------------------------
  logic        acc;
  logic        wr;
  logic        rd;
  logic [11:0] a;
  assign acc = PSEL & PENABLE & ~PREADY;
  assign wr  = acc & PWRITE;
  assign rd  = acc & ~PWRITE;
  assign a   = {PADDR[11:2], 2'b00};

  // Matches a two-word group at its base address.
  function automatic logic in_pair(input logic [11:0] adr, input logic [11:0] base);
    in_pair = (adr == base) || (adr == base + 12'h004);
  endfunction : in_pair

  logic        soft_rst;
  logic        start_wr;
  logic [31:0] mode_r;
  logic [31:0] mask_r;
  logic [63:0] key1_r;
  logic [63:0] key2_r;
  logic [63:0] key3_r;
  logic [63:0] idata_r;
  logic [63:0] odata_r;
  logic [63:0] iv_r;
  logic [15:0] rcnt_r;
  logic [15:0] rncnt_r;
  logic [15:0] tcnt_r;
  logic [15:0] tncnt_r;
  logic        done_r;
  logic        erx_r;
  logic        etx_r;
  logic        ill_r;
  logic [1:0]  typ_r;
  logic [5:0]  cnt_r;
  tdr_state_e  state_r;
  logic        busy;
  logic        dma;
  logic        last_output_mode;
  logic        manual_auto;
  logic        in_wr;
  logic        out_rd;
  logic        wo_rd;
  logic [31:0] status;

  assign soft_rst    = wr && (a == ADDR_CTRL) && PWDATA[CTRL_SRST];
  assign start_wr    = wr && (a == ADDR_CTRL) && PWDATA[CTRL_START];
  assign busy        = (state_r == TDR_BUSY);
  assign dma         = (mode_r[MODE_SM_LO +: 2] == SM_DMA);
  assign last_output_mode         = mode_r[MODE_LOD];
  assign manual_auto = (mode_r[MODE_SM_LO +: 2] == SM_MANUAL) ||
                       (mode_r[MODE_SM_LO +: 2] == SM_AUTO);
  assign in_wr       = wr && in_pair(a, ADDR_IDATA);
  assign out_rd      = rd && in_pair(a, ADDR_ODATA);
  // Write-only locations: control, enable/disable, keys, input data and vector.
  assign wo_rd = rd && ((a == ADDR_CTRL) || (a == ADDR_IEN) || (a == ADDR_IDIS) ||
                 in_pair(a, ADDR_KEY1) || in_pair(a, ADDR_KEY2) || in_pair(a, ADDR_KEY3) ||
                 in_pair(a, ADDR_IDATA) || in_pair(a, ADDR_IV));

  //----------------------------------------------------------------------------
  // Mode and interrupt mask
  //----------------------------------------------------------------------------
  // Mode writes are accepted even while busy; the access is flagged as illegal.
  always_ff @(posedge CLOCK) begin
    if (SRST || soft_rst) begin
      mode_r <= 32'h0000_0000;
    end else if (wr && a == ADDR_MODE) begin
      mode_r <= PWDATA & MODE_WMASK;
    end
  end

  // Set by enable writes, cleared by disable writes; zeros leave bits alone.
  always_ff @(posedge CLOCK) begin
    if (SRST || soft_rst) begin
      mask_r <= 32'h0000_0000;
    end else if (wr && a == ADDR_IEN) begin
      mask_r <= mask_r | (PWDATA & IRQ_BITS); // [RULE21]
    end else if (wr && a == ADDR_IDIS) begin
      mask_r <= mask_r & ~(PWDATA & IRQ_BITS); // [RULE21]
    end
  end

  //----------------------------------------------------------------------------
  // Write-only key, data and vector words
  //----------------------------------------------------------------------------
  // Word one fills the upper half so the block reads first-to-last from the top.
  always_ff @(posedge CLOCK) begin
    if (SRST || soft_rst) begin
      key1_r  <= 64'h0;
      key2_r  <= 64'h0;
      key3_r  <= 64'h0;
      idata_r <= 64'h0;
      iv_r    <= 64'h0;
    end else if (wr) begin
      if (a == ADDR_KEY1)            key1_r[63:32]  <= PWDATA; // [RULE14]
      if (a == ADDR_KEY1 + 12'h004)  key1_r[31:0]   <= PWDATA; // [RULE14]
      if (a == ADDR_KEY2)            key2_r[63:32]  <= PWDATA; // [RULE14]
      if (a == ADDR_KEY2 + 12'h004)  key2_r[31:0]   <= PWDATA; // [RULE14]
      if (a == ADDR_KEY3)            key3_r[63:32]  <= PWDATA; // [RULE14]
      if (a == ADDR_KEY3 + 12'h004)  key3_r[31:0]   <= PWDATA; // [RULE14]
      if (a == ADDR_IDATA)           idata_r[63:32] <= PWDATA; // [RULE17]
      if (a == ADDR_IDATA + 12'h004) idata_r[31:0]  <= PWDATA; // [RULE17]
      if (a == ADDR_IV)              iv_r[63:32]    <= PWDATA; // [RULE19]
      if (a == ADDR_IV + 12'h004)    iv_r[31:0]     <= PWDATA; // [RULE19]
    end
  end

  // Keys the datapath sees; unused keys are replaced so stale words never leak in.
  always_ff @(posedge CLOCK) begin
    if (SRST) begin
      ENGINE_KEY1  <= 64'h0;
      ENGINE_KEY2  <= 64'h0;
      ENGINE_KEY3  <= 64'h0;
      ENGINE_BLOCK <= 64'h0;
      ENGINE_IV    <= 64'h0;
    end else begin
      ENGINE_KEY1  <= key1_r;
      ENGINE_KEY2  <= mode_r[MODE_TRIPLE] ? key2_r : key1_r; // [RULE15]
      ENGINE_KEY3  <= (mode_r[MODE_TRIPLE] && !mode_r[MODE_KEYSEL]) ? key3_r : // [RULE16]
                      key1_r; // [RULE22]
      ENGINE_BLOCK <= idata_r;
      ENGINE_IV    <= iv_r;
    end
  end

  //----------------------------------------------------------------------------
  // DMA counters kept locally for the buffer flags
  //----------------------------------------------------------------------------
  // The DMA channel reports counter exhaustion by pulses; counts mirror software writes.
  always_ff @(posedge CLOCK) begin
    if (SRST) begin
      rcnt_r  <= 16'h0;
      rncnt_r <= 16'h0;
      tcnt_r  <= 16'h0;
      tncnt_r <= 16'h0;
      erx_r   <= 1'b0;
      etx_r   <= 1'b0;
    end else begin
      if (wr && a == ADDR_RCNT)  rcnt_r  <= PWDATA[15:0];
      if (wr && a == ADDR_RNCNT) rncnt_r <= PWDATA[15:0];
      if (wr && a == ADDR_TCNT)  tcnt_r  <= PWDATA[15:0];
      if (wr && a == ADDR_TNCNT) tncnt_r <= PWDATA[15:0];
      if (RX_DMA_ZERO) begin
        erx_r <= 1'b1; // [RULE7]
      end else if (wr && (a == ADDR_RCNT || a == ADDR_RNCNT)) begin
        erx_r <= 1'b0; // [RULE7]
      end
      if (TX_DMA_ZERO) begin
        etx_r <= 1'b1; // [RULE8]
      end else if (wr && (a == ADDR_TCNT || a == ADDR_TNCNT)) begin
        etx_r <= 1'b0; // [RULE8]
      end
    end
  end

  //----------------------------------------------------------------------------
  // Engine sequencer
  //----------------------------------------------------------------------------
  // Manual starts on the start bit, auto and DMA on the second input word.
  always_ff @(posedge CLOCK) begin
    if (SRST || soft_rst) begin
      state_r      <= TDR_IDLE;
      cnt_r        <= 6'd0;
      ENGINE_START <= 1'b0;
      odata_r      <= 64'h0;
    end else begin
      ENGINE_START <= 1'b0;
      case (state_r)
        TDR_IDLE, TDR_DONE: begin
          if ((start_wr && mode_r[MODE_SM_LO +: 2] == SM_MANUAL) ||
              (wr && a == ADDR_IDATA + 12'h004 && mode_r[MODE_SM_LO +: 2] != SM_MANUAL)) begin
            state_r      <= TDR_BUSY;
            cnt_r        <= ENGINE_CYCLES;
            ENGINE_START <= 1'b1;
          end
        end
        TDR_BUSY: begin
          if (cnt_r == 6'd1) begin
            state_r <= TDR_DONE;
            odata_r <= ENGINE_RESULT; // [RULE18]
          end
          cnt_r <= cnt_r - 6'd1;
        end
        default: state_r <= TDR_IDLE;
      endcase
    end
  end

  //----------------------------------------------------------------------------
  // Status flags
  //----------------------------------------------------------------------------
  // Completion outranks any clear but a soft reset landing on the same edge.
  always_ff @(posedge CLOCK) begin
    if (SRST || soft_rst) begin
      done_r <= 1'b0; // [RULE3]
    end else if (busy && cnt_r == 6'd1) begin
      done_r <= 1'b1; // [RULE2] [RULE6]
    end else if (start_wr) begin
      done_r <= 1'b0; // [RULE3]
    end else if (dma && ENGINE_START) begin
      done_r <= 1'b0; // [RULE6]
    end else if (manual_auto && !last_output_mode && out_rd) begin
      done_r <= 1'b0; // [RULE4]
    end else if (manual_auto && last_output_mode && in_wr) begin
      done_r <= 1'b0; // [RULE5]
    end
  end

  // Illegal accesses; the newest code replaces the old one.
  always_ff @(posedge CLOCK) begin
    if (SRST || soft_rst) begin
      ill_r <= 1'b0; // [RULE11]
      typ_r <= 2'h0; // [RULE13]
    end else if (wo_rd) begin
      ill_r <= 1'b1; // [RULE24]
      typ_r <= ILL_WO_RD; // [RULE12] [RULE24]
    end else if (busy && in_wr && dma) begin
      ill_r <= 1'b1; // [RULE11]
      typ_r <= ILL_IN_DMA; // [RULE12]
    end else if (busy && out_rd) begin
      ill_r <= 1'b1;
      typ_r <= ILL_OUT_RD; // [RULE12] [RULE13]
    end else if (busy && wr && a == ADDR_MODE) begin
      ill_r <= 1'b1;
      typ_r <= ILL_MODE_WR; // [RULE12]
    end
  end

  // Status word as software reads it; the buffer-level flags are derived live from the counts.
  always_comb begin
    status          = 32'h0;
    status[ST_DONE] = done_r;
    status[ST_ERX]  = erx_r;
    status[ST_ETX]  = etx_r;
    status[ST_RXF]  = (rcnt_r == 16'h0) && (rncnt_r == 16'h0); // [RULE9]
    status[ST_TXE]  = (tcnt_r == 16'h0) && (tncnt_r == 16'h0); // [RULE10]
    status[ST_ILL]  = ill_r;
    status[ST_TYP +: 2] = typ_r;
  end

  // Request follows masked status, registered so the pin is glitch free.
  always_ff @(posedge CLOCK) begin
    if (SRST) begin
      IRQ <= 1'b0;
    end else begin
      IRQ <= |(status & mask_r & IRQ_BITS); // [RULE23]
    end
  end

  //----------------------------------------------------------------------------
  // APB answer: one wait state, so every transfer ends in the second access cycle
  //----------------------------------------------------------------------------
  always_ff @(posedge CLOCK) begin
    if (SRST) begin
      PREADY  <= 1'b0;
      PRDATA  <= 32'h0;
      PSLVERR <= 1'b0;
    end else begin
      PREADY  <= acc;
      PSLVERR <= 1'b0;
      PRDATA  <= 32'h0;
      if (rd) begin
        case (a)
          ADDR_MODE:              PRDATA <= mode_r;
          ADDR_IMASK:             PRDATA <= mask_r; // [RULE1]
          ADDR_ISTAT:             PRDATA <= status;
          ADDR_ODATA:             PRDATA <= odata_r[63:32]; // [RULE18]
          ADDR_ODATA + 12'h004:   PRDATA <= odata_r[31:0]; // [RULE18]
          ADDR_RCNT:              PRDATA <= {16'h0, rcnt_r};
          ADDR_RNCNT:             PRDATA <= {16'h0, rncnt_r};
          ADDR_TCNT:              PRDATA <= {16'h0, tcnt_r};
          ADDR_TNCNT:             PRDATA <= {16'h0, tncnt_r};
          default:                PRDATA <= 32'h0; // [RULE14] [RULE24]
        endcase
      end
    end
  end
endmodule : tdr_regs

// ===== tb/tdr_regs_monitor.sv
// Checker for the DES register block, watching the top module ports only.
`timescale 1ns/100ps
module tdr_regs_monitor
  import tdr_pkg::*;
(
  input wire logic        CLOCK,
  input wire logic        SRST,
  input wire logic        PSEL,
  input wire logic        PENABLE,
  input wire logic        PWRITE,
  input wire logic [11:0] PADDR,
  input wire logic [31:0] PWDATA,
  input wire logic [31:0] PRDATA,
  input wire logic        PREADY,
  input wire logic        PSLVERR,
  input wire logic        RX_DMA_ZERO,
  input wire logic        TX_DMA_ZERO,
  input wire logic [63:0] ENGINE_RESULT,
  input wire logic [63:0] ENGINE_BLOCK,
  input wire logic [63:0] ENGINE_KEY1,
  input wire logic [63:0] ENGINE_KEY2,
  input wire logic [63:0] ENGINE_KEY3,
  input wire logic [63:0] ENGINE_IV,
  input wire logic        ENGINE_START,
  input wire logic        IRQ
);
  logic [31:0] md_r;
  logic [31:0] msk_r;
  logic [3:0]  qt_r;
  wire         wr_done = PREADY && PWRITE;
  wire         soft_rst = wr_done && PADDR == ADDR_CTRL && PWDATA[CTRL_SRST];

  // Shadow of mode and mask, updated as each write completes on the bus.
  always_ff @(posedge CLOCK) begin
    if (SRST || soft_rst) begin
      md_r <= '0;
      msk_r <= '0;
    end else if (wr_done && PADDR == ADDR_MODE) begin
      md_r <= PWDATA & MODE_WMASK;
    end else if (wr_done && PADDR == ADDR_IEN) begin
      msk_r <= msk_r | (PWDATA & IRQ_BITS);
    end else if (wr_done && PADDR == ADDR_IDIS) begin
      msk_r <= msk_r & ~PWDATA;
    end
  end

  // Engine outputs trail storage, so the key checks wait a few quiet cycles.
  always_ff @(posedge CLOCK) begin
    if (SRST || wr_done) qt_r <= '0;
    else if (qt_r != 4'hf) qt_r <= qt_r + 4'h1;
  end

  // ----------------------------------------
  // Properties
  // ----------------------------------------
  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (SRST);

  AST_ANSWER:
    assert property (PSEL && PENABLE && !PREADY |=> PREADY) else $error("late ready");
  AST_ONE_SHOT:
    assert property (PREADY |=> !PREADY) else $error("ready too long");
  AST_IDLE_DATA:
    assert property (!PREADY |-> PRDATA == 32'h0 && !PSLVERR) else $error("idle data");
  AST_WO_ZERO:
    assert property (PREADY && !PWRITE && (PADDR[11:4] inside {8'h02, 8'h03}
      || PADDR[11:3] inside {9'h008, 9'h00c}) |-> PRDATA == 32'h0) else $error("wo read");
  AST_KEY2_SINGLE:
    assert property (qt_r > 4'h2 && !md_r[MODE_TRIPLE] |-> ENGINE_KEY2 == ENGINE_KEY1)
      else $error("key two used");
  AST_KEY3_SKIP:
    assert property (qt_r > 4'h2 && !(md_r[MODE_TRIPLE] && !md_r[MODE_KEYSEL])
      |-> ENGINE_KEY3 == ENGINE_KEY1) else $error("key three used");
  AST_IRQ_MASKED:
    assert property (qt_r > 4'h2 && msk_r == 32'h0 |-> !IRQ) else $error("irq unmasked");
  AST_DONE_TIME:
    assert property (ENGINE_START && msk_r == 32'h1 |-> ##[48:50] IRQ) else $error("no done");
  AST_START_PULSE:
    assert property (ENGINE_START |=> !ENGINE_START) else $error("start too long");
endmodule : tdr_regs_monitor

// ===== tb/tdr_engine_model.sv
// Behavioural model of the cipher engine that sits behind the register block.
`timescale 1ns/100ps
module tdr_engine_model
  import tdr_pkg::*;
(
  input  wire logic        CLOCK,
  input  wire logic        SRST,
  input  wire logic        ENGINE_START,
  input  wire logic [63:0] ENGINE_BLOCK,
  input  wire logic [63:0] ENGINE_KEY1,
  input  wire logic [63:0] ENGINE_KEY2,
  input  wire logic [63:0] ENGINE_KEY3,
  input  wire logic [63:0] ENGINE_IV,
  output logic      [63:0] ENGINE_RESULT
);
  logic [6:0]  busy_r;
  logic [63:0] mix;

  // Count through one block; the result is valid over the whole block and a few cycles past its end.
  always_ff @(posedge CLOCK) begin
    if (SRST) busy_r <= '0;
    else if (ENGINE_START) busy_r <= 7'd1;
    else if (busy_r != 7'd0 && busy_r < {1'b0, ENGINE_CYCLES} + 7'd3) busy_r <= busy_r + 7'd1;
    else busy_r <= '0;
  end

  // Stand-in transform; outside the window the inverse shows, so stale sampling is caught.
  assign mix = ENGINE_BLOCK ^ ENGINE_KEY1 ^ {ENGINE_KEY2[31:0], ENGINE_KEY2[63:32]}
             ^ {ENGINE_KEY3[15:0], ENGINE_KEY3[63:16]} ^ ENGINE_IV;
  assign ENGINE_RESULT = (busy_r != 7'd0) ? mix : ~mix;
endmodule : tdr_engine_model

// ===== tb/tb.sv
// Top-level bench for the DES register block with an engine model and a checker.
`timescale 1ns/100ps
module tb;
  import tdr_pkg::*;
  logic        CLOCK = 1'b0;
  logic        SRST = 1'b1;
  logic        PSEL = 1'b0;
  logic        PENABLE = 1'b0;
  logic        PWRITE = 1'b0;
  logic [11:0] PADDR = '0;
  logic [31:0] PWDATA = '0;
  logic        RX_DMA_ZERO = 1'b0;
  logic        TX_DMA_ZERO = 1'b0;
  logic [31:0] PRDATA;
  logic        PREADY, PSLVERR, ENGINE_START, IRQ;
  logic [63:0] ENGINE_RESULT, ENGINE_BLOCK, ENGINE_KEY1, ENGINE_KEY2, ENGINE_KEY3, ENGINE_IV;
  logic [63:0] key [3];
  logic [63:0] blk = '0;
  logic [63:0] iv = '0;
  logic [63:0] r;
  logic [31:0] mds [3] = '{32'h1000, 32'h1002, 32'h1012};
  logic [31:0] expq [$];
  int          miscompares = 0;
  int          n_checks = 0;

  always #20 CLOCK = ~CLOCK;

  tdr_regs uut (.CLOCK, .SRST, .PSEL, .PENABLE, .PWRITE, .PADDR, .PWDATA, .PRDATA, .PREADY,
    .PSLVERR, .RX_DMA_ZERO, .TX_DMA_ZERO, .ENGINE_RESULT, .ENGINE_BLOCK, .ENGINE_KEY1,
    .ENGINE_KEY2, .ENGINE_KEY3, .ENGINE_IV, .ENGINE_START, .IRQ);
  tdr_engine_model eng (.CLOCK, .SRST, .ENGINE_START, .ENGINE_BLOCK, .ENGINE_KEY1,
    .ENGINE_KEY2, .ENGINE_KEY3, .ENGINE_IV, .ENGINE_RESULT);

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  task automatic report_and_stop();
    $display("Checks %0d, mismatches %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : report_and_stop

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // Interrupt level is a result of its own kind, compared where it is settled.
  task automatic chk_irq(input logic exp);
    n_checks++;
    if (IRQ !== exp) begin
      miscompares++;
      $display("MISMATCH at %0t: got %h expected %h", $time, IRQ, exp);
    end
  endtask : chk_irq

  // One APB transfer; the request is held until ready is sampled high.
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    PSEL <= 1'b1;
    PWRITE <= w;
    PADDR <= a;
    PWDATA <= d;
    @(posedge CLOCK);
    PENABLE <= 1'b1;
    for (n = 0; n < 20 && PREADY !== 1'b1; n++) @(posedge CLOCK);
    if (n == 20) begin
      miscompares++;
      report_and_stop();
    end
    PSEL <= 1'b0;
    PENABLE <= 1'b0;
    @(posedge CLOCK);
  endtask : apb

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask : wr

  task automatic rd(input logic [11:0] a, input logic [31:0] e);
    expq.push_back(e);
    apb(1'b0, a, 32'h0);
  endtask : rd

  function automatic logic [63:0] res(input logic [31:0] md);
    logic [63:0] k2;
    logic [63:0] k3;
    k2 = md[MODE_TRIPLE] ? key[1] : key[0];
    k3 = (md[MODE_TRIPLE] && !md[MODE_KEYSEL]) ? key[2] : key[0];
    return blk ^ key[0] ^ {k2[31:0], k2[63:32]} ^ {k3[15:0], k3[63:16]} ^ iv;
  endfunction : res

  // Mode, keys, vector (chaining modes only) and block; word one is the upper half.
  task automatic load(input logic [31:0] md);
    wr(ADDR_MODE, md);
    for (int i = 0; i < 3; i++) begin
      key[i] = {$urandom, $urandom};
      wr(ADDR_KEY1 + 12'(8 * i), key[i][63:32]);
      wr(ADDR_KEY1 + 12'(8 * i + 4), key[i][31:0]);
    end
    if (md[12]) begin
      iv = {$urandom, $urandom};
      wr(ADDR_IV, iv[63:32]);
      wr(ADDR_IV + 12'h4, iv[31:0]);
    end
    blk = {$urandom, $urandom};
    wr(ADDR_IDATA, blk[63:32]);
    wr(ADDR_IDATA + 12'h4, blk[31:0]);
  endtask : load

  // Every completed read retires the oldest expectation.
  always @(posedge CLOCK) begin
    if (PREADY === 1'b1 && PWRITE === 1'b0) chk(PRDATA, expq.pop_front());
  end

  // A hang anywhere ends the run as a failure.
  initial begin
    repeat (20000) @(posedge CLOCK);
    miscompares++;
    report_and_stop();
  end

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    void'($urandom(4));
    repeat (5) @(posedge CLOCK);
    SRST <= 1'b0;
    @(posedge CLOCK);
    rd(ADDR_IMASK, 32'h0);
    rd(ADDR_ISTAT, 32'h18);
    wr(ADDR_IEN, IRQ_BITS | ($urandom & 32'hffff_fee0));
    wr(ADDR_IMASK, $urandom);
    rd(ADDR_IMASK, IRQ_BITS);
    wr(ADDR_IDIS, 32'h11e);
    rd(ADDR_IMASK, 32'h1);
    $display("Test reset and mask done");
    for (int i = 0; i < 2; i++) begin
      wr(i ? ADDR_TCNT : ADDR_RCNT, 32'h5);
      rd(ADDR_ISTAT, 32'h18 ^ (32'h8 << i));
      RX_DMA_ZERO <= (i == 0);
      TX_DMA_ZERO <= (i == 1);
      @(posedge CLOCK);
      RX_DMA_ZERO <= 1'b0;
      TX_DMA_ZERO <= 1'b0;
      rd(ADDR_ISTAT, 32'h18 ^ (32'h8 << i) | (32'h2 << i));
      wr(i ? ADDR_TNCNT : ADDR_RNCNT, 32'h0);
      rd(ADDR_ISTAT, 32'h18 ^ (32'h8 << i));
      wr(i ? ADDR_TCNT : ADDR_RCNT, 32'h0);
      rd(ADDR_ISTAT, 32'h18);
    end
    $display("Test buffer flags done");
    foreach (mds[j]) begin
      load(mds[j]);
      r = res(mds[j]);
      wr(ADDR_CTRL, 32'h1);
      repeat (60) @(posedge CLOCK);
      chk_irq(1'b1);
      rd(ADDR_ISTAT, 32'h19);
      rd(ADDR_ODATA, r[63:32]);
      rd(ADDR_ODATA + 12'h4, r[31:0]);
      rd(ADDR_ISTAT, 32'h18);
      chk_irq(1'b0);
    end
    $display("Test manual blocks done");
    wr(ADDR_CTRL, 32'h1);
    rd(ADDR_ODATA, r[63:32]);
    rd(ADDR_ISTAT, 32'h1118);
    wr(ADDR_MODE, 32'h1012);
    rd(ADDR_ISTAT, 32'h2118);
    rd(ADDR_KEY1, 32'h0);
    rd(ADDR_ISTAT, 32'h3118);
    repeat (60) @(posedge CLOCK);
    rd(ADDR_ISTAT, 32'h3119);
    load(32'h8200);
    wr(ADDR_IDATA, 32'h0);
    rd(ADDR_ISTAT, 32'h0118);
    repeat (60) @(posedge CLOCK);
    rd(ADDR_ISTAT, 32'h0119);
    wr(ADDR_CTRL, 32'h100);
    iv = '0;
    rd(ADDR_ISTAT, 32'h18);
    rd(ADDR_IMASK, 32'h0);
    $display("Test illegal access done");
    wr(ADDR_IEN, 32'h1);
    load(32'h8100);
    r = res(32'h8100);
    repeat (60) @(posedge CLOCK);
    rd(ADDR_ODATA, r[63:32]);
    rd(ADDR_ISTAT, 32'h19);
    wr(ADDR_IDATA, 32'h0);
    rd(ADDR_ISTAT, 32'h18);
    $display("Test last output mode done");
    report_and_stop();
  end
endmodule : tb

bind tdr_regs tdr_regs_monitor mon (.CLOCK, .SRST, .PSEL, .PENABLE, .PWRITE, .PADDR, .PWDATA,
  .PRDATA, .PREADY, .PSLVERR, .RX_DMA_ZERO, .TX_DMA_ZERO, .ENGINE_RESULT, .ENGINE_BLOCK,
  .ENGINE_KEY1, .ENGINE_KEY2, .ENGINE_KEY3, .ENGINE_IV, .ENGINE_START, .IRQ);
